// file: ctrl_model.sv
// Controller model: commands, masks and write data
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
	input wire logic clk,
	output var logic cke,
	output var logic cs_n,
	output var logic [2:0] cmd,
	output var logic [1:0] ba,
	output var logic [11:0] addr,
	output var logic [3:0] dqm,
	output var logic [31:0] dq_in
);
	// Nanosecond minimums rounded up to 5 ns cycles
	localparam int ROW_TO_COL = 4;
	localparam int POWER_UP = 20000;
	initial begin
		cke = 1'b1;
		cs_n = 1'b1;
		cmd = 3'h7;
		ba = 2'h0;
		addr = 12'h000;
		dqm = 4'h0;
		dq_in = 32'h0;
	end
	task automatic issue(input logic [2:0] c, input logic [1:0] b,
		input logic [11:0] a, input logic [3:0] m, input logic [31:0] d);
		@(posedge clk);
		cs_n <= 1'b0;
		cmd <= c;
		ba <= b;
		addr <= a;
		dqm <= m;
		// Idle data lines toggle so a stale word never matches
		dq_in <= (c == 3'h4 || c == 3'h7) ? d : ~dq_in;
	endtask
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge clk);
			cs_n <= 1'b1;
			dqm <= 4'h0;
			dq_in <= ~dq_in;
		end
	endtask
	task automatic power_up();
		repeat (POWER_UP) @(posedge clk);
		repeat (2) begin
			issue(sdram_timing_pkg::CMD_REFRESH, 2'h0, 12'h000, 4'h0, 32'h0);
			idle(12);
		end
	endtask
	task automatic mode(input logic [11:0] op);
		idle(1);
		// Stop with no burst in flight must be harmless
		issue(sdram_timing_pkg::CMD_STOP, 2'h0, 12'h000, 4'h0, 32'h0);
		idle(1);
		issue(sdram_timing_pkg::CMD_PRECHARGE, 2'h0, 12'h400, 4'h0, 32'h0);
		idle(4);
		issue(sdram_timing_pkg::CMD_LOAD_MODE, 2'h0, op, 4'h0, 32'h0);
		idle(2);
	endtask
	task automatic activate(input logic [1:0] b, input logic [11:0] r);
		issue(sdram_timing_pkg::CMD_ACTIVE, b, r, 4'h0, 32'h0);
		idle(ROW_TO_COL);
	endtask
	task automatic set_cke(input logic v);
		@(posedge clk);
		cke <= v;
	endtask
	task automatic self_refresh();
		issue(sdram_timing_pkg::CMD_REFRESH, 2'h0, 12'h000, 4'h0, 32'h0);
		cke <= 1'b0;
		idle(1);
	endtask
	task automatic wake();
		set_cke(1'b1);
		idle(14);
	endtask
endmodule // ctrl_model
`default_nettype wire

// file: sdram_command_timing_test.sv
// Self-checking bench for the DRAM device core
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
miscompares++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module sdram_command_timing_test;
	logic clk_sys, resetn, cke, cs_n, suspended, self_refresh;
	logic [2:0] cmd;
	logic [1:0] ba;
	logic [11:0] addr;
	logic [3:0] dqm, dq_oe_n;
	logic [31:0] dq_in, dq_out;
	int miscompares, cmp_count, seed, c0, row;
	logic [31:0] mem [int];
	ctrl_model u_ctrl_model (.clk(clk_sys), .cke(cke), .cs_n(cs_n),
		.cmd(cmd), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in));
	sdram_device_core u_sdram_device_core (.CLK_SYS(clk_sys), .RESETN(resetn),
		.CKE(cke), .CS_N(cs_n), .RAS_N(cmd[2]), .CAS_N(cmd[1]), .WE_N(cmd[0]),
		.BA(ba), .ADDR(addr), .DQM(dqm), .DQ_IN(dq_in), .DQ_OUT(dq_out),
		.DQ_OE_N(dq_oe_n), .SUSPENDED(suspended), .SELF_REFRESH(self_refresh));
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic conclude();
		if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	function automatic logic [31:0] bm(input logic [3:0] m);
		return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
	endfunction
	// Mask of the output word i edges after the read command's mask
	function automatic logic [3:0] msk(input int i, input logic [3:0] m0,
		input logic [3:0] m1);
		return (i == 0) ? m0 : (i == 1) ? m1 : 4'h0;
	endfunction
	task automatic wr(input int b, c, input logic [3:0] m);
		logic [31:0] d0, d1;
		int k0, k1;
		d0 = $random(seed);
		d1 = $random(seed);
		k0 = (b * 4 + row) * 256 + c;
		k1 = k0 ^ 1;
		u_ctrl_model.issue(sdram_timing_pkg::CMD_WRITE, 2'(b), 12'(c), m,
			d0);
		u_ctrl_model.issue(3'h7, 2'(b), 12'($random(seed)), m, d1);
		mem[k0] = mem.exists(k0) ? (mem[k0] & bm(m)) | (d0 & ~bm(m)) : d0;
		mem[k1] = mem.exists(k1) ? (mem[k1] & bm(m)) | (d1 & ~bm(m)) : d1;
	endtask
	// Beats wrap inside the aligned pair; a second read or, with cut set, a precharge cuts the first
	task automatic rd(input int b, c, cl, input logic [3:0] m, input bit cut);
		logic [31:0] e0, e1;
		logic [3:0] m1, x0, x1, x2;
		int k;
		k = (b * 4 + row) * 256 + c;
		e0 = mem[k];
		e1 = mem[k ^ 1];
		m1 = 4'($random(seed));
		x0 = msk(cl - 2, m, m1);
		x1 = cut ? 4'hF : msk(cl - 1, m, m1);
		x2 = cut ? 4'hF : msk(cl, m, m1);
		// Gap clears the write mask, which would float the first word
		u_ctrl_model.idle(1);
		u_ctrl_model.issue(sdram_timing_pkg::CMD_READ, 2'(b), 12'(c), m,
			32'($random(seed)));
		if (cut)
			u_ctrl_model.issue(sdram_timing_pkg::CMD_PRECHARGE, 2'(b),
				12'($random(seed)) & 12'hBFF, m1, 32'($random(seed)));
		else
			u_ctrl_model.issue(sdram_timing_pkg::CMD_READ, 2'(b),
				12'(c ^ 1), m1, 32'($random(seed)));
		u_ctrl_model.idle(cl);
		#1;
		`CHK("oe0", x0, dq_oe_n)
		`CHK("word0", e0 & ~bm(x0), dq_out & ~bm(x0))
		u_ctrl_model.idle(1);
		#1;
		`CHK("oe1", x1, dq_oe_n)
		`CHK("word1", e1 & ~bm(x1), dq_out & ~bm(x1))
		u_ctrl_model.idle(1);
		#1;
		`CHK("oe2", x2, dq_oe_n)
		if (!cut) `CHK("word2", e0 & ~bm(x2), dq_out & ~bm(x2))
		u_ctrl_model.idle(1);
		#1;
		`CHK("float", 4'hF, dq_oe_n)
	endtask
	initial begin
		// Whole run stays far inside one refresh interval
		repeat (25000) @(posedge clk_sys);
		miscompares++;
		conclude();
	end
	initial begin
		seed = 58;
		resetn = 1'b0;
		repeat (8) @(posedge clk_sys);
		resetn <= 1'b1;
		u_ctrl_model.power_up();
		#1;
		`CHK("autoref", 1'b0, self_refresh)
		for (int cl = 1; cl <= 3; cl++) begin
			u_ctrl_model.mode(12'(cl * 16 + 1));
			row = $random(seed) & 3;
			u_ctrl_model.activate(2'h0, 12'(row));
			u_ctrl_model.activate(2'h1, 12'(row));
			for (int b = 0; b < 2; b++) begin
				c0 = $random(seed) & 32'hFF;
				wr(b, c0, 4'h0);
				wr(b, c0, 4'($random(seed)));
				rd(b, c0, cl, 4'($random(seed)), b == 1);
			end
		end
		u_ctrl_model.set_cke(1'b0);
		#1;
		`CHK("run", 1'b0, suspended)
		@(posedge clk_sys);
		#1;
		`CHK("susp", 1'b1, suspended)
		u_ctrl_model.set_cke(1'b1);
		#1;
		`CHK("hold", 1'b1, suspended)
		@(posedge clk_sys);
		#1;
		`CHK("resume", 1'b0, suspended)
		u_ctrl_model.mode(12'h031);
		u_ctrl_model.self_refresh();
		#1;
		`CHK("selfref", 1'b1, self_refresh)
		u_ctrl_model.wake();
		#1;
		`CHK("selfexit", 1'b0, self_refresh)
		// Array contents must survive self refresh
		u_ctrl_model.activate(2'h1, 12'(row));
		rd(1, c0, 3, 4'($random(seed)), 0);
		conclude();
	end
endmodule // sdram_command_timing_test
`default_nettype wire

// file: sdram_device_core.sv
// Command, burst and data-path core of a four-bank synchronous DRAM
`timescale 1ns/1ps
`default_nettype none
module sdram_device_core #(
	parameter int DATA_W = 32,
	parameter int ROW_BITS = 2,
	parameter int COL_BITS = 8
) (
	input wire logic CLK_SYS,
	input wire logic RESETN,
	input wire logic CKE,
	input wire logic CS_N,
	input wire logic RAS_N,
	input wire logic CAS_N,
	input wire logic WE_N,
	input wire logic [1:0] BA,
	input wire logic [11:0] ADDR,
	input wire logic [DATA_W/8-1:0] DQM,
	input wire logic [DATA_W-1:0] DQ_IN,
	output var logic [DATA_W-1:0] DQ_OUT,
	output var logic [DATA_W/8-1:0] DQ_OE_N,
	output var logic SUSPENDED,
	output var logic SELF_REFRESH
);
	localparam int NB = DATA_W / 8;
	localparam int IDX_W = 2 + ROW_BITS + COL_BITS;
	localparam int LEN_W = COL_BITS + 1;
	localparam int READ_PIPE_W = sdram_timing_pkg::READ_PIPE_DEPTH;

	// Only ROW_BITS of the row are kept to bound the array size
	logic [DATA_W-1:0] mem [0:(1<<IDX_W)-1];

	logic [11:0] mode, next_mode;
	logic [3:0] bank_open, next_bank_open;
	logic [3:0][ROW_BITS-1:0] open_row, next_open_row;
	logic burst_on, next_burst_on;
	logic burst_wr, next_burst_wr;
	logic burst_ap, next_burst_ap;
	logic [1:0] burst_bank, next_burst_bank;
	logic [COL_BITS-1:0] burst_col, next_burst_col;
	logic [COL_BITS-1:0] burst_mask, next_burst_mask;
	logic [LEN_W-1:0] burst_left, next_burst_left;
	logic [READ_PIPE_W-1:0] rd_v, next_rd_v;
	logic [READ_PIPE_W-1:0][DATA_W-1:0] rd_d, next_rd_d;
	logic [NB-1:0] dqm_d1, next_dqm_d1;
	logic [NB-1:0] dqm_d2, next_dqm_d2;
	logic [DATA_W-1:0] next_dq_out;
	logic [NB-1:0] next_oe_n;
	logic next_suspended, next_self;

	logic [2:0] cmd;
	logic en, live, col_cmd, stop, pre_rd;
	logic b_go, b_wr, b_ap;
	logic [1:0] b_bank;
	logic [COL_BITS-1:0] b_col, b_mask;
	logic [LEN_W-1:0] b_left, new_len;
	logic [IDX_W-1:0] beat_idx;
	logic [1:0] cl;
	logic wr_go;

	function automatic logic [LEN_W-1:0] burst_len(input logic [2:0] code);
		logic [LEN_W-1:0] len;
		len = LEN_W'(1);
		if (code == sdram_timing_pkg::BL_CODE_FULL) begin
			len = LEN_W'(1) << COL_BITS;
		end else if (code < 3'h4) begin
			len = LEN_W'(1) << code;
		end
		return len;
	endfunction

	always_comb begin
		cmd = {RAS_N, CAS_N, WE_N};
		// Clock suspend, power-down and self refresh freeze everything
		en = !SUSPENDED && !SELF_REFRESH;
		live = en && !CS_N;
		col_cmd = live && (cmd == sdram_timing_pkg::CMD_READ ||
			cmd == sdram_timing_pkg::CMD_WRITE);
		stop = live && burst_on && (cmd == sdram_timing_pkg::CMD_STOP ||
			(cmd == sdram_timing_pkg::CMD_PRECHARGE &&
			(ADDR[sdram_timing_pkg::AUTO_PRECHARGE_SELECT_BIT] ||
			BA == burst_bank)));
		pre_rd = stop && !burst_wr && cmd == sdram_timing_pkg::CMD_PRECHARGE;
		cl = mode[sdram_timing_pkg::MODE_CL_LSB +: 2];
		if (cl == 2'h0 || mode[sdram_timing_pkg::MODE_CL_LSB + 2]) begin
			cl = sdram_timing_pkg::CL_DEFAULT;
		end
		new_len = burst_len(mode[sdram_timing_pkg::MODE_BL_LSB +: 3]);
		if (cmd == sdram_timing_pkg::CMD_WRITE &&
			mode[sdram_timing_pkg::MODE_WRITE_SINGLE_BIT]) begin
			new_len = LEN_W'(1);
		end
		// A new column command cuts off any burst in flight
		if (col_cmd) begin
			b_go = 1'b1;
			b_wr = cmd == sdram_timing_pkg::CMD_WRITE;
			b_ap = ADDR[sdram_timing_pkg::AUTO_PRECHARGE_SELECT_BIT];
			b_bank = BA;
			b_col = ADDR[COL_BITS-1:0];
			b_left = new_len;
			b_mask = COL_BITS'(new_len - LEN_W'(1));
		end else begin
			b_go = en && burst_on && !stop;
			b_wr = burst_wr;
			b_ap = burst_ap;
			b_bank = burst_bank;
			b_col = burst_col;
			b_left = burst_left;
			b_mask = burst_mask;
		end
		beat_idx = {b_bank, open_row[b_bank], b_col};
		wr_go = b_go && b_wr;

		next_mode = mode;
		next_bank_open = bank_open;
		next_open_row = open_row;
		if (live && cmd == sdram_timing_pkg::CMD_LOAD_MODE) begin
			next_mode = ADDR;
		end
		if (live && cmd == sdram_timing_pkg::CMD_ACTIVE) begin
			next_bank_open[BA] = 1'b1;
			next_open_row[BA] = ADDR[ROW_BITS-1:0];
		end
		if (live && cmd == sdram_timing_pkg::CMD_PRECHARGE) begin
			if (ADDR[sdram_timing_pkg::AUTO_PRECHARGE_SELECT_BIT]) begin
				next_bank_open = 4'h0;
			end else begin
				next_bank_open[BA] = 1'b0;
			end
		end
		// Auto precharge closes the row once the last beat is done
		if (b_go && b_ap && b_left == LEN_W'(1)) begin
			next_bank_open[b_bank] = 1'b0;
		end

		next_burst_on = burst_on;
		next_burst_wr = burst_wr;
		next_burst_ap = burst_ap;
		next_burst_bank = burst_bank;
		next_burst_col = burst_col;
		next_burst_mask = burst_mask;
		next_burst_left = burst_left;
		if (stop) begin
			next_burst_on = 1'b0;
		end else if (b_go) begin
			next_burst_on = b_left > LEN_W'(1);
			next_burst_wr = b_wr;
			next_burst_ap = b_ap;
			next_burst_bank = b_bank;
			// Column wraps inside the burst-aligned block
			next_burst_col = (b_col & ~b_mask) |
				((b_col + COL_BITS'(1)) & b_mask);
			next_burst_mask = b_mask;
			next_burst_left = b_left - LEN_W'(1);
		end

		next_rd_v = rd_v;
		next_rd_d = rd_d;
		next_dqm_d1 = dqm_d1;
		next_dqm_d2 = dqm_d2;
		next_dq_out = DQ_OUT;
		next_oe_n = DQ_OE_N;
		if (en) begin
			next_rd_v = {rd_v[READ_PIPE_W-2:0], b_go && !b_wr};
			next_rd_d = {rd_d[READ_PIPE_W-2:0], mem[beat_idx]};
			next_dqm_d1 = DQM;
			// Mask needs two stages so it lands two edges after sampling
			next_dqm_d2 = dqm_d1;
			// Word fetched at the command edge leaves after cl edges
			next_dq_out = rd_d[cl - 2'h1];
			next_oe_n = ~{NB{rd_v[cl - 2'h1]}} | dqm_d2;
		end

		next_suspended = !CKE;
		next_self = SELF_REFRESH;
		if (SELF_REFRESH && CKE) begin
			next_self = 1'b0;
		end else if (live && cmd == sdram_timing_pkg::CMD_REFRESH) begin
			next_self = !CKE;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			mode <= sdram_timing_pkg::MODE_RESET;
			bank_open <= 4'h0;
			open_row <= '0;
			burst_on <= 1'b0;
			burst_wr <= 1'b0;
			burst_ap <= 1'b0;
			burst_bank <= 2'h0;
			burst_col <= '0;
			burst_mask <= '0;
			burst_left <= '0;
			rd_v <= '0;
			rd_d <= '0;
			dqm_d1 <= '1;
			dqm_d2 <= '1;
			DQ_OUT <= '0;
			DQ_OE_N <= '1;
			SUSPENDED <= 1'b1;
			SELF_REFRESH <= 1'b0;
		end else begin
			mode <= next_mode;
			bank_open <= next_bank_open;
			open_row <= next_open_row;
			burst_on <= next_burst_on;
			burst_wr <= next_burst_wr;
			burst_ap <= next_burst_ap;
			burst_bank <= next_burst_bank;
			burst_col <= next_burst_col;
			burst_mask <= next_burst_mask;
			burst_left <= next_burst_left;
			rd_v <= next_rd_v;
			rd_d <= next_rd_d;
			dqm_d1 <= next_dqm_d1;
			dqm_d2 <= next_dqm_d2;
			DQ_OUT <= next_dq_out;
			DQ_OE_N <= next_oe_n;
			SUSPENDED <= next_suspended;
			SELF_REFRESH <= next_self;
		end
	end

	// Array has no reset; contents are undefined until written
	always_ff @(posedge CLK_SYS) begin
		for (int i = 0; i < NB; i++) begin
			if (wr_go && !DQM[i]) begin
				mem[beat_idx][i*8 +: 8] <= DQ_IN[i*8 +: 8];
			end
		end
	end

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESETN);

	col_accept_a: assert property (col_cmd [*2] |=>
		burst_bank == $past(BA) && burst_wr == $past(!WE_N))
		else $error("back-to-back column command not taken");
	suspend_entry_a: assert property (en && !CKE && burst_on &&
		!stop && !col_cmd |-> ##1 !$stable(burst_left) ##1
		$stable(burst_left))
		else $error("suspend did not start one clock after enable low");
	suspend_exit_a: assert property (SUSPENDED && !SELF_REFRESH && CKE &&
		burst_on ##1 !stop && !col_cmd |-> $stable(burst_left)
		##1 !$stable(burst_left))
		else $error("suspend did not end one clock after enable high");
	write_mask_a: assert property (wr_go && !DQM[0] |=>
		mem[$past(beat_idx)][7:0] == $past(DQ_IN[7:0]))
		else $error("unmasked write byte not stored");
	write_block_a: assert property (wr_go && DQM[0] |=>
		mem[$past(beat_idx)][7:0] == $past(mem[beat_idx][7:0]))
		else $error("masked write byte was stored");
	read_mask_a: assert property (en && DQM[1] ##1 en ##1 en |=>
		DQ_OE_N[1])
		else $error("read mask did not float byte two clocks later");
	pre_float3_a: assert property (pre_rd && cl == 2'h3 ##1
		(en && !col_cmd) [*3] |=> &DQ_OE_N)
		else $error("outputs not floated three clocks after precharge");
	pre_float2_a: assert property (pre_rd && cl == 2'h2 ##1
		(en && !col_cmd) [*2] |=> &DQ_OE_N)
		else $error("outputs not floated two clocks after precharge");
	self_enter_a: assert property (live &&
		cmd == sdram_timing_pkg::CMD_REFRESH |=> SELF_REFRESH == $past(!CKE))
		else $error("refresh command took the wrong refresh mode");
	ap_close_a: assert property (col_cmd && bank_open[BA] &&
		ADDR[sdram_timing_pkg::AUTO_PRECHARGE_SELECT_BIT] &&
		new_len == LEN_W'(1) |=> !bank_open[$past(BA)])
		else $error("auto precharge left the row open");
	ap_keep_a: assert property (col_cmd && bank_open[BA] &&
		!ADDR[sdram_timing_pkg::AUTO_PRECHARGE_SELECT_BIT] |=>
		bank_open[$past(BA)])
		else $error("row closed without auto precharge");

	read_burst_c: cover property (col_cmd && !b_wr ##1 burst_on [*3]);
	write_burst_c: cover property (col_cmd && b_wr ##1 wr_go [*3]);
	self_refresh_c: cover property (SELF_REFRESH ##1 !SELF_REFRESH);
	pre_cut_c: cover property (pre_rd);

endmodule // sdram_device_core
`default_nettype wire

// file: sdram_timing_pkg.sv
// Constants shared by the synchronous DRAM device core
// Contract
// - Column commands may follow every clock
// - Suspend begins one clock after low enable
// - Suspend ends one clock after high enable
// - Write mask blocks same-clock data word
// - Read mask floats outputs two clocks later
// - Precharge floats read outputs after latency
// - Refresh command: auto if enable high, self otherwise
// - Address bit ten selects per-access auto precharge
package sdram_timing_pkg;

	// Command codes on {row strobe, column strobe, write enable}
	localparam logic [2:0] CMD_LOAD_MODE = 3'h0;
	localparam logic [2:0] CMD_REFRESH = 3'h1;
	localparam logic [2:0] CMD_PRECHARGE = 3'h2;
	localparam logic [2:0] CMD_ACTIVE = 3'h3;
	localparam logic [2:0] CMD_WRITE = 3'h4;
	localparam logic [2:0] CMD_READ = 3'h5;
	localparam logic [2:0] CMD_STOP = 3'h6;

	localparam int AUTO_PRECHARGE_SELECT_BIT = 10;
	localparam int MODE_BL_LSB = 0;
	localparam int MODE_CL_LSB = 4;
	localparam int MODE_WRITE_SINGLE_BIT = 9;
	localparam logic [11:0] MODE_RESET = 12'h020;
	localparam logic [2:0] BL_CODE_FULL = 3'h7;

	// Deepest read latency; the read pipe has one stage per clock
	localparam int READ_PIPE_DEPTH = 3;
	localparam logic [1:0] CL_DEFAULT = 2'h3;

endpackage
